// ===== logic/banked_data_memory_flags.sv
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Sixty-four banks of 128 bytes each
// - Address: six bank bits, seven offset bits
// - Direct access uses the bank select register
// - Twelve core registers mirrored in every bank
// - Reach memory directly or via pointers
// - Peripheral space: 20 or 100 bytes
// - Up to 80 general bytes per bank
// - General ram linear through pointers too
// - Sixteen common bytes shared by all banks
// - Unimplemented locations read as zero
// - Computed flags override write to flags
// - Timeout and powerdown flags ignore writes
// - Flag bits seven to five read zero
// - Timeout set power-up/clear/sleep, cleared timeout
// - Powerdown set power-up/clear, cleared by sleep
// - Power-on reset values; others keep arithmetic
// - Zero flag marks a zero result
// - Digit carry out of bit three
// - Carry out of the top bit
// - Subtract by two's complement, inverted borrow
// - Rotate loads carry with shifted-out bit
module banked_data_memory_flags (
   // Clock and resets
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_soft_reset,
   // Memory access from the core
   input wire banked_mem_pkg::mem_req_t i_req,
   output logic o_rvalid,
   output logic [7:0] o_rdata,
   // Flag updates from the arithmetic unit, and power events
   input wire banked_mem_pkg::flag_update_t i_flags,
   input wire banked_mem_pkg::power_event_t i_power,
   // Arithmetic helper
   input wire logic i_alu_go,
   input wire logic [1:0] i_alu_op,
   input wire logic [7:0] i_alu_a,
   input wire logic [7:0] i_alu_b,
   output logic [7:0] o_alu_result,
   output logic [3:0] o_alu_flags,
   // Register views
   output logic [7:0] o_arith_reset_flags,
   output logic [5:0] o_bank_select,
   output logic [7:0] o_working_accumulator
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [7:0] core_ff [banked_mem_pkg::CORE_COUNT];
   logic [7:0] gpr_mem [banked_mem_pkg::GPR_TOTAL];
   logic [7:0] sfr_mem [banked_mem_pkg::SFR_TOTAL];
   logic [7:0] common_mem [banked_mem_pkg::COMMON_BYTES];
   logic [2:0] arith_ff;
   logic [1:0] pwr_ff;
   logic [4:0] flags_ff;
   assign flags_ff = {pwr_ff, arith_ff};

   // ------------------------------------------------------------
   // Address formation
   // ------------------------------------------------------------
   logic [15:0] ptr0;
   logic [15:0] ptr1;
   logic [15:0] ptr_sel;
   logic linear_hit;
   logic [12:0] full_addr;
   logic [5:0] bank;
   logic [6:0] ofs;
   logic [12:0] lin_idx;

   assign ptr0 = {core_ff[banked_mem_pkg::REG_POINTER0_HIGH],
                  core_ff[banked_mem_pkg::REG_POINTER0_LOW]};
   assign ptr1 = {core_ff[banked_mem_pkg::REG_POINTER1_HIGH],
                  core_ff[banked_mem_pkg::REG_POINTER1_LOW]};
   assign ptr_sel = (i_req.mode == banked_mem_pkg::MODE_PTR1) ? ptr1 : ptr0;
   assign linear_hit = (i_req.mode != banked_mem_pkg::MODE_DIRECT) &&
                       (ptr_sel >= banked_mem_pkg::LINEAR_BASE) &&
                       (ptr_sel <= banked_mem_pkg::LINEAR_LIMIT);
   assign lin_idx = ptr_sel[12:0];

   always_comb begin
      if (i_req.mode == banked_mem_pkg::MODE_DIRECT) begin
         full_addr = {core_ff[banked_mem_pkg::REG_BANK_SELECT][5:0], i_req.offset};
      end else begin
         full_addr = ptr_sel[12:0];
      end
   end

   assign bank = full_addr[12:7];
   assign ofs = full_addr[6:0];

   // ------------------------------------------------------------
   // Region decode
   // ------------------------------------------------------------
   logic hit_core;
   logic hit_common;
   logic hit_sfr;
   logic hit_gpr;
   logic [6:0] sfr_len;
   logic [12:0] gpr_idx;
   logic [12:0] sfr_idx;
   logic [12:0] gpr_rel;

   assign sfr_len = (bank >= banked_mem_pkg::SFR_HI_FIRST_BANK) ?
                    7'(banked_mem_pkg::SFR_HI_BYTES) : 7'(banked_mem_pkg::SFR_LO_BYTES);
   assign hit_core = !linear_hit && (ofs <= banked_mem_pkg::OFS_CORE_LAST);
   assign hit_common = !linear_hit && (ofs >= banked_mem_pkg::OFS_COMMON_FIRST);
   assign hit_sfr = !linear_hit && !hit_core && !hit_common &&
                    (ofs < 7'(banked_mem_pkg::OFS_SFR_FIRST + sfr_len));
   // General ram follows the peripheral space and stops below common ram
   assign hit_gpr = !linear_hit && !hit_core && !hit_common && !hit_sfr &&
                    (bank < banked_mem_pkg::SFR_HI_FIRST_BANK) &&
                    (ofs >= banked_mem_pkg::OFS_GPR_LO_FIRST);
   assign gpr_rel = 13'(ofs - banked_mem_pkg::OFS_GPR_LO_FIRST);
   assign gpr_idx = linear_hit ? lin_idx :
                    13'(bank * banked_mem_pkg::GPR_BYTES) + gpr_rel;
   assign sfr_idx = 13'(bank * banked_mem_pkg::SFR_HI_BYTES) +
                    13'(ofs - banked_mem_pkg::OFS_SFR_FIRST);

   logic gpr_ok;
   assign gpr_ok = (linear_hit || hit_gpr) &&
                   (gpr_idx < 13'(banked_mem_pkg::GPR_TOTAL));

   // ------------------------------------------------------------
   // Arithmetic unit
   // ------------------------------------------------------------
   logic [8:0] sum;
   logic [4:0] low_sum;
   logic [7:0] b_eff;
   logic cin;
   logic [7:0] alu_res;
   logic alu_c;
   logic alu_dc;

   always_comb begin
      b_eff = i_alu_b;
      cin = 1'b0;
      if (i_alu_op == 2'h1) begin
         b_eff = ~i_alu_b;
         cin = 1'b1;
      end
      sum = 9'(i_alu_a) + 9'(b_eff) + 9'(cin);
      low_sum = 5'(i_alu_a[3:0]) + 5'(b_eff[3:0]) + 5'(cin);
      alu_res = sum[7:0];
      alu_c = sum[8];
      alu_dc = low_sum[banked_mem_pkg::NIBBLE_BIT];
      case (i_alu_op)
         2'h2: begin
            alu_res = {i_alu_a[6:0], flags_ff[banked_mem_pkg::FLAG_CARRY]};
            alu_c = i_alu_a[7];
            alu_dc = flags_ff[banked_mem_pkg::FLAG_DIGIT];
         end
         2'h3: begin
            alu_res = {flags_ff[banked_mem_pkg::FLAG_CARRY], i_alu_a[7:1]};
            alu_c = i_alu_a[0];
            alu_dc = flags_ff[banked_mem_pkg::FLAG_DIGIT];
         end
         default: begin
            alu_res = sum[7:0];
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_alu_result <= 8'h00;
         o_alu_flags <= 4'h0;
      end else if (i_alu_go) begin
         o_alu_result <= alu_res;
         o_alu_flags <= {1'b0, (alu_res == 8'h00), alu_dc, alu_c};
      end
   end

   // ------------------------------------------------------------
   // Flag register
   // ------------------------------------------------------------
   logic flag_wr;
   assign flag_wr = i_req.valid && i_req.write && hit_core &&
                    (ofs[3:0] == banked_mem_pkg::REG_ARITH_RESET_FLAGS);

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         arith_ff <= 3'h0;
      end else if (i_flags.update) begin
         arith_ff[banked_mem_pkg::FLAG_ZERO] <= i_flags.zero;
         arith_ff[banked_mem_pkg::FLAG_DIGIT] <= i_flags.digit;
         arith_ff[banked_mem_pkg::FLAG_CARRY] <= i_flags.carry;
      end else if (flag_wr) begin
         arith_ff <= i_req.wdata[2:0];
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         pwr_ff <= 2'h3;
      end else if (i_power.wdt_clear) begin
         pwr_ff[banked_mem_pkg::FLAG_TIMEOUT - banked_mem_pkg::FLAG_POWERDOWN] <= 1'b1;
         pwr_ff[0] <= 1'b1;
      end else if (i_power.sleep) begin
         pwr_ff[banked_mem_pkg::FLAG_TIMEOUT - banked_mem_pkg::FLAG_POWERDOWN] <= 1'b1;
         pwr_ff[0] <= 1'b0;
      end else if (i_power.wdt_timeout) begin
         pwr_ff[banked_mem_pkg::FLAG_TIMEOUT - banked_mem_pkg::FLAG_POWERDOWN] <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Core register writes
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < banked_mem_pkg::CORE_COUNT; gi++) begin : g_core
         if (gi == 3) begin : g_flag_slot
            always_ff @(posedge i_sys_clk or posedge i_reset) begin
               if (i_reset) begin
                  core_ff[gi] <= banked_mem_pkg::CORE_RESET;
               end
            end
         end else begin : g_reg
            always_ff @(posedge i_sys_clk or posedge i_reset) begin
               if (i_reset) begin
                  core_ff[gi] <= banked_mem_pkg::CORE_RESET;
               end else if (i_soft_reset && (gi == 8)) begin
                  core_ff[gi] <= banked_mem_pkg::CORE_RESET;
               end else if (i_req.valid && i_req.write && hit_core &&
                            (ofs[3:0] == 4'(gi))) begin
                  core_ff[gi] <= i_req.wdata;
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Ram writes
   // ------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_req.valid && i_req.write) begin
         if (gpr_ok) begin
            gpr_mem[gpr_idx] <= i_req.wdata;
         end
         if (hit_sfr) begin
            sfr_mem[sfr_idx] <= i_req.wdata;
         end
         if (hit_common) begin
            common_mem[ofs[3:0]] <= i_req.wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (hit_core) begin
         if (ofs[3:0] == banked_mem_pkg::REG_ARITH_RESET_FLAGS) begin
            rd_mux = {3'h0, flags_ff};
         end else begin
            rd_mux = core_ff[ofs[3:0]];
         end
      end else if (hit_common) begin
         rd_mux = common_mem[ofs[3:0]];
      end else if (hit_sfr) begin
         rd_mux = sfr_mem[sfr_idx];
      end else if (gpr_ok) begin
         rd_mux = gpr_mem[gpr_idx];
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rvalid <= 1'b0;
         o_rdata <= 8'h00;
      end else begin
         o_rvalid <= i_req.valid && !i_req.write;
         o_rdata <= (i_req.valid && !i_req.write) ? rd_mux : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Register views
   // ------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_arith_reset_flags <= 8'h18;
         o_bank_select <= banked_mem_pkg::BANK_RESET;
         o_working_accumulator <= 8'h00;
      end else begin
         o_arith_reset_flags <= {3'h0, flags_ff} & banked_mem_pkg::FLAG_IMPL_MASK;
         o_bank_select <= core_ff[banked_mem_pkg::REG_BANK_SELECT][5:0];
         o_working_accumulator <= core_ff[banked_mem_pkg::REG_WORKING_ACCUMULATOR];
      end
   end

endmodule : banked_data_memory_flags

`default_nettype wire

// ===== logic/banked_mem_pkg.sv
package banked_mem_pkg;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int BANK_COUNT = 64;
   localparam int BANK_BYTES = 128;
   localparam int ADDR_W = 13;
   localparam int BANK_W = 6;
   localparam int OFS_W = 7;
   localparam int DATA_W = 8;
   localparam int CORE_COUNT = 12;
   localparam int SFR_LO_BYTES = 20;
   localparam int SFR_HI_BYTES = 100;
   localparam int GPR_BYTES = 80;
   localparam int COMMON_BYTES = 16;
   localparam logic [5:0] SFR_HI_FIRST_BANK = 6'h3C;
   localparam logic [6:0] OFS_CORE_LAST = 7'h0B;
   localparam logic [6:0] OFS_SFR_FIRST = 7'h0C;
   localparam logic [6:0] OFS_GPR_LO_FIRST = 7'h20;
   localparam logic [6:0] OFS_GPR_HI_FIRST = 7'h70;
   localparam logic [6:0] OFS_COMMON_FIRST = 7'h70;
   localparam int GPR_TOTAL = BANK_COUNT * GPR_BYTES;
   localparam int GPR_AW = 13;
   localparam int SFR_TOTAL = BANK_COUNT * SFR_HI_BYTES;
   localparam int SFR_AW = 13;
   // Linear window for pointer access to general ram
   localparam logic [15:0] LINEAR_BASE = 16'h2000;
   localparam logic [15:0] LINEAR_LIMIT = 16'h3FFF;

   // ------------------------------------------------------------
   // Core register offsets
   // ------------------------------------------------------------
   localparam logic [3:0] REG_INDIRECT_DATA_0 = 4'h0;
   localparam logic [3:0] REG_INDIRECT_DATA_1 = 4'h1;
   localparam logic [3:0] REG_PROGRAM_COUNTER_LOW = 4'h2;
   localparam logic [3:0] REG_ARITH_RESET_FLAGS = 4'h3;
   localparam logic [3:0] REG_POINTER0_LOW = 4'h4;
   localparam logic [3:0] REG_POINTER0_HIGH = 4'h5;
   localparam logic [3:0] REG_POINTER1_LOW = 4'h6;
   localparam logic [3:0] REG_POINTER1_HIGH = 4'h7;
   localparam logic [3:0] REG_BANK_SELECT = 4'h8;
   localparam logic [3:0] REG_WORKING_ACCUMULATOR = 4'h9;
   localparam logic [3:0] REG_PROGRAM_COUNTER_UPPER_LATCH = 4'hA;
   localparam logic [3:0] REG_INTERRUPT_CONTROL = 4'hB;

   // ------------------------------------------------------------
   // Flag register fields and resets
   // ------------------------------------------------------------
   localparam int FLAG_CARRY = 0;
   localparam int FLAG_DIGIT = 1;
   localparam int FLAG_ZERO = 2;
   localparam int FLAG_POWERDOWN = 3;
   localparam int FLAG_TIMEOUT = 4;
   localparam int NIBBLE_BIT = 4;
   localparam logic [7:0] FLAG_IMPL_MASK = 8'h1F;
   localparam logic [7:0] CORE_RESET = 8'h00;
   localparam logic [5:0] BANK_RESET = 6'h00;

   // ------------------------------------------------------------
   // Access types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_DIRECT,
      MODE_PTR0,
      MODE_PTR1
   } access_mode_t;

   typedef struct packed {
      logic valid;
      logic write;
      access_mode_t mode;
      logic [OFS_W-1:0] offset;
      logic [DATA_W-1:0] wdata;
   } mem_req_t;

   typedef struct packed {
      logic update;
      logic zero;
      logic digit;
      logic carry;
   } flag_update_t;

   typedef struct packed {
      logic wdt_clear;
      logic sleep;
      logic wdt_timeout;
   } power_event_t;

endpackage : banked_mem_pkg

// ===== test/banked_data_memory_flags_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module banked_data_memory_flags_chk (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_soft_reset,
   input wire banked_mem_pkg::mem_req_t i_req,
   input wire logic o_rvalid,
   input wire logic [7:0] o_rdata,
   input wire banked_mem_pkg::flag_update_t i_flags,
   input wire banked_mem_pkg::power_event_t i_power,
   input wire logic i_alu_go,
   input wire logic [1:0] i_alu_op,
   input wire logic [7:0] i_alu_a,
   input wire logic [7:0] i_alu_b,
   input wire logic [7:0] o_alu_result,
   input wire logic [3:0] o_alu_flags,
   input wire logic [7:0] o_arith_reset_flags,
   input wire logic [5:0] o_bank_select,
   input wire logic [7:0] o_working_accumulator
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   logic go_ff;
   logic [8:0] sum_ff;
   logic [4:0] nib_ff;
   // Expected add or subtract result, one cycle later
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         go_ff <= 1'b0;
      end else begin
         go_ff <= i_alu_go && !i_alu_op[1];
      end
   end
   always_ff @(posedge i_sys_clk) begin
      sum_ff <= {1'b0, i_alu_a} + {1'b0, i_alu_b ^ {8{i_alu_op[0]}}} + {8'h00, i_alu_op[0]};
      nib_ff <= {1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0] ^ {4{i_alu_op[0]}}} + {4'h0, i_alu_op[0]};
   end
   sequence s_read; i_req.valid && !i_req.write; endsequence
   sequence s_sleep; i_power.sleep && !i_power.wdt_clear; endsequence
   property p_rd_answer; s_read |=> o_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_rd_idle; !o_rvalid |-> o_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   property p_upper; o_arith_reset_flags[7:5] == 3'h0; endproperty
   a_upper: assert property (p_upper) else $error("flag upper bits set");
   property p_por; $fell(i_reset) |-> o_arith_reset_flags == 8'h18; endproperty
   a_por: assert property (p_por) else $error("flag reset value wrong");
   property p_sleep; s_sleep |-> ##[1:2] o_arith_reset_flags[4:3] == 2'b10; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
   property p_wdt;
      i_power.wdt_timeout && !i_power.sleep && !i_power.wdt_clear |-> ##[1:2] !o_arith_reset_flags[4];
   endproperty
   a_wdt: assert property (p_wdt) else $error("timeout flag not cleared");
   property p_sum;
      go_ff |-> o_alu_result == sum_ff[7:0] && o_alu_flags[1:0] == {nib_ff[4], sum_ff[8]};
   endproperty
   a_sum: assert property (p_sum) else $error("add or subtract wrong");
   property p_zero; $past(i_alu_go) |-> o_alu_flags[2] == (o_alu_result == 8'h00); endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_soft; i_soft_reset |-> ##[1:2] o_bank_select == 6'h00; endproperty
   a_soft: assert property (p_soft) else $error("bank not cleared");
endmodule : banked_data_memory_flags_chk

bind banked_data_memory_flags banked_data_memory_flags_chk chk_u (.*);
`default_nettype wire

// ===== test/core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Core side: accesses, flag updates, power events, alu ops
// ------------------------------------------------------------
module core_model (
   // Clock
   input wire logic i_sys_clk,
   // Towards the block
   output var banked_mem_pkg::mem_req_t o_req,
   output logic [3:0] o_flags,
   output logic [2:0] o_power,
   output logic o_alu_go,
   output logic [1:0] o_alu_op,
   output logic [7:0] o_alu_a,
   output logic [7:0] o_alu_b,
   // Read answer
   input wire logic [7:0] i_rdata
);
   initial begin
      o_req = '0;
      o_flags = 4'h0;
      o_power = 3'h0;
      o_alu_go = 1'b0;
      o_alu_op = 2'h0;
      o_alu_a = 8'h00;
      o_alu_b = 8'h00;
   end
   // One access, with an optional arithmetic flag update driven in the same cycle
   task automatic acc(input logic [1:0] m, input logic w, input logic [6:0] o,
         input logic [7:0] d, input logic [3:0] f, output logic [7:0] q);
      @(posedge i_sys_clk);
      o_req <= '{1'b1, w, banked_mem_pkg::access_mode_t'(m), o, d};
      o_flags <= f;
      @(posedge i_sys_clk);
      o_req.valid <= 1'b0;
      o_req.offset <= ~o;
      o_req.wdata <= ~d;
      o_flags <= 4'h0;
      #1 q = i_rdata;
   endtask : acc
   task automatic ev(input logic [2:0] p);
      @(posedge i_sys_clk);
      o_power <= p;
      @(posedge i_sys_clk);
      o_power <= 3'h0;
   endtask : ev
   task automatic alu(input logic [1:0] op, input logic [7:0] a, input logic [7:0] b);
      @(posedge i_sys_clk);
      o_alu_go <= 1'b1;
      o_alu_op <= op;
      o_alu_a <= a;
      o_alu_b <= b;
      @(posedge i_sys_clk);
      o_alu_go <= 1'b0;
      o_alu_a <= ~a;
      o_alu_b <= ~b;
      #1;
   endtask : alu
endmodule : core_model
`default_nettype wire

// ===== test/test_banked_data_memory_flags.sv
`timescale 1ns/1ns
`default_nettype none
module test_banked_data_memory_flags;
   // ------------------------------------------------------------
   // Wiring, clock, watchdog
   // ------------------------------------------------------------
   logic i_sys_clk;
   logic i_reset;
   logic i_soft_reset;
   banked_mem_pkg::mem_req_t i_req;
   banked_mem_pkg::flag_update_t i_flags;
   banked_mem_pkg::power_event_t i_power;
   logic i_alu_go;
   logic [1:0] i_alu_op;
   logic [7:0] i_alu_a;
   logic [7:0] i_alu_b;
   logic o_rvalid;
   logic [7:0] o_rdata;
   logic [7:0] o_alu_result;
   logic [3:0] o_alu_flags;
   logic [7:0] o_arith_reset_flags;
   logic [5:0] o_bank_select;
   logic [7:0] o_working_accumulator;
   logic [7:0] rd;
   int n_mismatch;
   int n_checks;
   banked_data_memory_flags dut_u (.*);
   core_model core_u (.i_sys_clk(i_sys_clk), .o_req(i_req), .o_flags(i_flags),
      .o_power(i_power), .o_alu_go(i_alu_go), .o_alu_op(i_alu_op), .o_alu_a(i_alu_a),
      .o_alu_b(i_alu_b), .i_rdata(o_rdata));
   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      #40000;
      n_mismatch++;
      finish_test();
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [6:0] o, input logic [7:0] d);
      core_u.acc(2'h0, 1'b1, o, d, 4'h0, rd);
   endtask : wr
   task automatic rdd(input logic [6:0] o);
      core_u.acc(2'h0, 1'b0, o, 8'h00, 4'h0, rd);
      chk("read valid", {7'h00, o_rvalid}, 8'h01);
   endtask : rdd
   task automatic rdp(input logic [1:0] m);
      core_u.acc(m, 1'b0, 7'h00, 8'h00, 4'h0, rd);
   endtask : rdp
   task automatic alu_case(input logic [1:0] op, input logic [7:0] a, input logic [7:0] b,
         input logic [7:0] res, input logic [3:0] fl);
      core_u.acc(2'h0, 1'b0, 7'h00, 8'h00, 4'h9, rd);
      core_u.alu(op, a, b);
      chk("alu result", o_alu_result, res);
      chk("alu flags", {4'h0, o_alu_flags}, {4'h0, fl});
   endtask : alu_case
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_banks();
      rdd(7'h03);
      chk("flags after reset", rd, 8'h18);
      wr(7'h08, 8'h01);
      wr(7'h6F, 8'h11);
      wr(7'h09, 8'hA5);
      wr(7'h08, 8'h3B);
      wr(7'h6F, 8'h22);
      rdd(7'h09);
      chk("core mirror", rd, 8'hA5);
      chk("accumulator view", o_working_accumulator, 8'hA5);
      chk("bank view", {2'h0, o_bank_select}, 8'h3B);
      rdd(7'h6F);
      chk("bank 59 ram", rd, 8'h22);
      wr(7'h08, 8'h01);
      rdd(7'h6F);
      chk("bank 1 ram", rd, 8'h11);
   endtask : t_banks
   task automatic t_ptr();
      wr(7'h04, 8'hEF);
      wr(7'h05, 8'h00);
      rdp(2'h1);
      chk("pointer banked", rd, 8'h11);
      wr(7'h06, 8'hBF);
      wr(7'h07, 8'h32);
      rdp(2'h2);
      chk("pointer linear", rd, 8'h22);
      wr(7'h07, 8'h34);
      core_u.acc(2'h2, 1'b1, 7'h00, 8'h77, 4'h0, rd);
      rdp(2'h2);
      chk("beyond linear", rd, 8'h00);
      wr(7'h06, 8'h00);
      wr(7'h07, 8'h20);
      core_u.acc(2'h2, 1'b1, 7'h00, 8'h33, 4'h0, rd);
      wr(7'h08, 8'h00);
      rdd(7'h20);
      chk("linear write", rd, 8'h33);
      wr(7'h7F, 8'h5A);
      wr(7'h08, 8'h3F);
      rdd(7'h7F);
      chk("common ram", rd, 8'h5A);
   endtask : t_ptr
   task automatic t_flags();
      core_u.ev(3'h2);
      wr(7'h03, 8'hFF);
      rdd(7'h03);
      chk("flag write", rd, 8'h17);
      core_u.acc(2'h0, 1'b1, 7'h03, 8'h00, 4'hD, rd);
      rdd(7'h03);
      chk("update beats write", rd, 8'h15);
      core_u.ev(3'h1);
      rdd(7'h03);
      chk("timeout", rd, 8'h05);
      core_u.ev(3'h4);
      rdd(7'h03);
      chk("watchdog clear", rd, 8'h1D);
      @(posedge i_sys_clk) i_soft_reset <= 1'b1;
      @(posedge i_sys_clk) i_soft_reset <= 1'b0;
      rdd(7'h03);
      chk("soft reset flags", rd, 8'h1D);
      chk("flag view", o_arith_reset_flags, 8'h1D);
      rdd(7'h08);
      chk("soft reset bank", rd, 8'h00);
   endtask : t_flags
   task automatic t_alu();
      alu_case(2'h0, 8'h0F, 8'h01, 8'h10, 4'h2);
      alu_case(2'h0, 8'hFF, 8'h01, 8'h00, 4'h7);
      alu_case(2'h1, 8'h05, 8'h05, 8'h00, 4'h7);
      alu_case(2'h1, 8'h00, 8'h01, 8'hFF, 4'h0);
      alu_case(2'h2, 8'h80, 8'h00, 8'h01, 4'h1);
      alu_case(2'h3, 8'h02, 8'h00, 8'h81, 4'h0);
   endtask : t_alu
   initial begin
      i_reset = 1'b1;
      i_soft_reset = 1'b0;
      n_mismatch = 0;
      n_checks = 0;
      repeat (10) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      t_banks();
      t_ptr();
      t_flags();
      t_alu();
      finish_test();
   end
endmodule : test_banked_data_memory_flags
`default_nettype wire
